// ---- rtl/tic_pkg.sv ----
// Purpose: constants for the timer interrupt, command and flag block
// Assumes: 8-bit internal register bus, byte offsets within the timer
// Notes:   mode codes follow the event-action and waveform-mode fields
package tic_pkg;
   localparam logic [5:0] TIC_OFF_IRQ_A   = 6'h06;
   localparam logic [5:0] TIC_OFF_IRQ_B   = 6'h07;
   localparam logic [5:0] TIC_OFF_F_CLR   = 6'h08;
   localparam logic [5:0] TIC_OFF_F_SET   = 6'h09;
   localparam logic [5:0] TIC_OFF_G_CLR   = 6'h0A;
   localparam logic [5:0] TIC_OFF_G_SET   = 6'h0B;
   localparam logic [5:0] TIC_OFF_FLAGS   = 6'h0C;
   localparam logic [7:0] TIC_RST_BYTE    = 8'h00;
   // control f fields
   localparam int TIC_F_DIR  = 0;
   localparam int TIC_F_UPDATE_LOCK = 1;
   localparam int TIC_F_CMD  = 2;
   localparam int TIC_F_QIDX = 4;
   // interrupt flag fields and the control g buffer valid field
   localparam int TIC_I_OVF  = 0;
   localparam int TIC_I_ERR  = 1;
   localparam int TIC_I_CC   = 4;
   localparam int TIC_G_CCBV = 1;
   localparam logic [7:0] TIC_F_MASK     = 8'h13;
   localparam logic [7:0] TIC_G_MASK     = 8'h1F;
   localparam logic [7:0] TIC_FLAGS_MASK = 8'hF3;
   localparam logic [7:0] TIC_A_MASK     = 8'h0F;
   localparam logic [1:0] TIC_CMD_UPDATE  = 2'h1;
   localparam logic [1:0] TIC_CMD_RESTART = 2'h2;
   localparam logic [1:0] TIC_CMD_RESET   = 2'h3;
   localparam logic [2:0] TIC_EV_CAPT = 3'h1;
   localparam logic [2:0] TIC_EV_FRQ  = 3'h5;
   localparam logic [2:0] TIC_EV_PW   = 3'h6;
   localparam logic [2:0] TIC_WG_NORMAL = 3'h0;
   localparam logic [1:0] TIC_LVL_OFF   = 2'h0;
endpackage : tic_pkg

// ---- rtl/tic_irq_ctrl.sv ----
// Purpose: interrupt levels, control f/g set-clear registers and interrupt flags of the timer
// Assumes: bus strobes and datapath events arrive on clk; one access per cycle
// Notes:   all outputs are registered, so reads and requests lag one cycle
`timescale 1ns/1ps
module tic_irq_ctrl
   import tic_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [5:0] bus_addr,
   input  wire logic [7:0] bus_wdata,
   input  wire logic       bus_wr,
   input  wire logic       bus_rd,
   input  wire logic       bus_dma,
   output logic      [7:0] bus_rdata,
   input  wire logic [2:0] event_action,
   input  wire logic [2:0] waveform_mode,
   input  wire logic       timer_off,
   input  wire logic       has_waveform_extension,
   input  wire logic       update_cond,
   input  wire logic       top_event,
   input  wire logic       bottom_event,
   input  wire logic [3:0] cc_match,
   input  wire logic [3:0] cc_capture,
   input  wire logic [3:0] cc_buf_overflow,
   input  wire logic       fault_detect,
   input  wire logic       bad_index,
   input  wire logic       index_seen,
   input  wire logic       leave_zero,
   input  wire logic       hw_dir_set,
   input  wire logic       hw_dir_clr,
   input  wire logic [3:0] cc_buf_written,
   input  wire logic       per_buf_written,
   input  wire logic [3:0] cc_read,
   input  wire logic [3:0] dma_cc_access,
   input  wire logic       dma_cnt_per_write,
   input  wire logic       vec_ovf_ack,
   input  wire logic       vec_err_ack,
   input  wire logic [3:0] vec_cc_ack,
   output logic            cmd_update,
   output logic            cmd_restart,
   output logic            cmd_hard_reset,
   output logic            transfer_buffers,
   output logic      [3:0] copy_cc_buffer,
   output logic            count_down,
   output logic            quad_index_flag,
   output logic      [3:0] channel_dma_req,
   output logic            overflow_dma_req,
   output logic      [1:0] overflow_irq_level,
   output logic      [1:0] error_irq_level,
   output logic      [7:0] channel_irq_level,
   output logic            overflow_irq,
   output logic            error_irq,
   output logic      [3:0] channel_irq
);

   // ************************************************************
   // register state
   // ************************************************************
   logic [7:0] irq_level_ctrl_a_r;
   logic [7:0] irq_level_ctrl_b_r;
   logic [7:0] control_f_r;
   logic [7:0] control_f_nxt;
   logic [7:0] buffer_valid_r;
   logic [7:0] buffer_valid_nxt;
   logic [7:0] interrupt_flags_r;
   logic [7:0] interrupt_flags_nxt;

   // ************************************************************
   // address decode
   // ************************************************************
   wire cpu_wr   = bus_wr & ~bus_dma;
   wire wr_a     = bus_wr && bus_addr == TIC_OFF_IRQ_A;
   wire wr_b     = bus_wr && bus_addr == TIC_OFF_IRQ_B;
   wire wr_fclr  = bus_wr && bus_addr == TIC_OFF_F_CLR;
   wire wr_fset  = bus_wr && bus_addr == TIC_OFF_F_SET;
   wire wr_gclr  = bus_wr && bus_addr == TIC_OFF_G_CLR;
   wire wr_gset  = bus_wr && bus_addr == TIC_OFF_G_SET;
   wire wr_flags = bus_wr && bus_addr == TIC_OFF_FLAGS;
   wire unused_cpu = cpu_wr;

   wire capture_mode = event_action == TIC_EV_CAPT ||
                       event_action == TIC_EV_FRQ ||
                       event_action == TIC_EV_PW;
   wire wave_mode    = waveform_mode != TIC_WG_NORMAL;

   // ************************************************************
   // command decode
   // ************************************************************
   wire [1:0] cmd_code   = bus_wdata[TIC_F_CMD +: 2];
   wire       cmd_write  = wr_fset;
   wire       do_update  = cmd_write && cmd_code == TIC_CMD_UPDATE;
   wire       do_restart = cmd_write && cmd_code == TIC_CMD_RESTART;
   wire       do_hreset  = cmd_write && cmd_code == TIC_CMD_RESET && timer_off;
   wire       any_update = update_cond | do_update;
   // lock only holds back transfers in compare operation
   wire       xfer_ok    = any_update & (~control_f_r[TIC_F_UPDATE_LOCK] | capture_mode);

   // ************************************************************
   // control f next value
   // ************************************************************
   wire [7:0] f_set = (wr_fset ? bus_wdata & TIC_F_MASK : TIC_RST_BYTE);
   wire [7:0] f_clr = (wr_fclr ? bus_wdata & TIC_F_MASK : TIC_RST_BYTE);
   always_comb begin
      control_f_nxt = (control_f_r & ~f_clr) | f_set;
      if (hw_dir_clr)
         control_f_nxt[TIC_F_DIR] = 1'b0;
      if (hw_dir_set)
         control_f_nxt[TIC_F_DIR] = 1'b1;
      if (leave_zero)
         control_f_nxt[TIC_F_QIDX] = 1'b0;
      if (index_seen)
         control_f_nxt[TIC_F_QIDX] = 1'b1;
   end

   // ************************************************************
   // flags and buffer valid, per channel
   // ************************************************************
   wire [3:0] cc_flag_now = interrupt_flags_r[TIC_I_CC +: 4];
   wire [3:0] cc_flag_w1c = wr_flags ? bus_wdata[TIC_I_CC +: 4] : 4'h0;
   logic [3:0] cc_flag_new;
   logic [3:0] ccbv_new;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ch
         wire bv_now  = buffer_valid_r[TIC_G_CCBV + gi];
         wire bv_sw_s = wr_gset & bus_wdata[TIC_G_CCBV + gi];
         wire bv_sw_c = wr_gclr & bus_wdata[TIC_G_CCBV + gi];
         wire flag_clr = cc_flag_w1c[gi] | dma_cc_access[gi] |
                         (capture_mode ? cc_read[gi] : vec_cc_ack[gi]);
         wire bv_set   = capture_mode ? cc_capture[gi] : cc_buf_written[gi];
         wire bv_clr   = capture_mode ? flag_clr : xfer_ok;
         // capture flag follows the next valid state, else a clearing read is undone by the stale valid bit
         wire flag_set = capture_mode ? ccbv_new[gi] : cc_match[gi];
         // set wins so a same-cycle event is kept
         assign cc_flag_new[gi] = flag_set | (cc_flag_now[gi] & ~flag_clr);
         assign ccbv_new[gi]    = bv_set | bv_sw_s | (bv_now & ~bv_clr & ~bv_sw_c);
      end
   endgenerate

   wire err_set = (wave_mode & ~capture_mode & fault_detect & has_waveform_extension) |
                  (capture_mode & |cc_buf_overflow) |
                  bad_index;
   wire err_clr = vec_err_ack | (wr_flags & bus_wdata[TIC_I_ERR]);
   wire ovf_set = top_event | bottom_event;
   wire ovf_clr = vec_ovf_ack | dma_cnt_per_write | (wr_flags & bus_wdata[TIC_I_OVF]);

   wire pbv_now = buffer_valid_r[0];
   wire pbv_new = per_buf_written | (wr_gset & bus_wdata[0]) |
                  (pbv_now & ~xfer_ok & ~(wr_gclr & bus_wdata[0]));

   always_comb begin
      interrupt_flags_nxt = TIC_RST_BYTE;
      interrupt_flags_nxt[TIC_I_CC +: 4] = cc_flag_new;
      interrupt_flags_nxt[TIC_I_ERR] = err_set | (interrupt_flags_r[TIC_I_ERR] & ~err_clr);
      interrupt_flags_nxt[TIC_I_OVF] = ovf_set | (interrupt_flags_r[TIC_I_OVF] & ~ovf_clr);
      buffer_valid_nxt = TIC_RST_BYTE;
      buffer_valid_nxt[TIC_G_CCBV +: 4] = ccbv_new;
      buffer_valid_nxt[0] = pbv_new;
   end

   // ************************************************************
   // read mux
   // ************************************************************
   logic [7:0] rdata_nxt;
   always_comb begin
      unique case (bus_addr)
         TIC_OFF_IRQ_A: rdata_nxt = irq_level_ctrl_a_r;
         TIC_OFF_IRQ_B: rdata_nxt = irq_level_ctrl_b_r;
         TIC_OFF_F_CLR,
         TIC_OFF_F_SET: rdata_nxt = control_f_r & TIC_F_MASK;
         TIC_OFF_G_CLR,
         TIC_OFF_G_SET: rdata_nxt = buffer_valid_r & TIC_G_MASK;
         TIC_OFF_FLAGS: rdata_nxt = interrupt_flags_r & TIC_FLAGS_MASK;
         default:       rdata_nxt = TIC_RST_BYTE;
      endcase
      if (!bus_rd)
         rdata_nxt = TIC_RST_BYTE;
   end

   // level copies and gates use the value being written so they line up with the register
   wire [7:0] lvl_a_nxt = wr_a ? (bus_wdata & TIC_A_MASK) : irq_level_ctrl_a_r;
   wire [7:0] lvl_b_nxt = wr_b ? bus_wdata : irq_level_ctrl_b_r;
   wire [1:0] lvl_err = lvl_a_nxt[3:2];
   wire [1:0] lvl_ovf = lvl_a_nxt[1:0];
   logic [3:0] cc_irq_nxt;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_irq
         assign cc_irq_nxt[gi] = interrupt_flags_nxt[TIC_I_CC + gi] &&
                                 lvl_b_nxt[2*gi +: 2] != TIC_LVL_OFF;
      end
   endgenerate

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_level_ctrl_a_r <= TIC_RST_BYTE;
         irq_level_ctrl_b_r <= TIC_RST_BYTE;
         control_f_r        <= TIC_RST_BYTE;
         buffer_valid_r     <= TIC_RST_BYTE;
         interrupt_flags_r  <= TIC_RST_BYTE;
      end else begin
         irq_level_ctrl_a_r <= lvl_a_nxt;
         irq_level_ctrl_b_r <= lvl_b_nxt;
         control_f_r       <= control_f_nxt;
         buffer_valid_r    <= buffer_valid_nxt;
         interrupt_flags_r <= interrupt_flags_nxt;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_rdata          <= TIC_RST_BYTE;
         cmd_update         <= 1'b0;
         cmd_restart        <= 1'b0;
         cmd_hard_reset     <= 1'b0;
         transfer_buffers   <= 1'b0;
         copy_cc_buffer     <= 4'h0;
         count_down         <= 1'b0;
         quad_index_flag    <= 1'b0;
         channel_dma_req    <= 4'h0;
         overflow_dma_req   <= 1'b0;
         overflow_irq_level <= 2'h0;
         error_irq_level    <= 2'h0;
         channel_irq_level  <= 8'h00;
         overflow_irq       <= 1'b0;
         error_irq          <= 1'b0;
         channel_irq        <= 4'h0;
      end else begin
         bus_rdata          <= rdata_nxt;
         cmd_update         <= do_update;
         cmd_restart        <= do_restart;
         cmd_hard_reset     <= do_hreset;
         transfer_buffers   <= xfer_ok;
         copy_cc_buffer     <= {4{xfer_ok & ~capture_mode}};
         count_down         <= control_f_nxt[TIC_F_DIR];
         quad_index_flag    <= control_f_nxt[TIC_F_QIDX];
         channel_dma_req    <= interrupt_flags_nxt[TIC_I_CC +: 4];
         overflow_dma_req   <= interrupt_flags_nxt[TIC_I_OVF];
         overflow_irq_level <= lvl_ovf;
         error_irq_level    <= lvl_err;
         channel_irq_level  <= lvl_b_nxt;
         overflow_irq       <= interrupt_flags_nxt[TIC_I_OVF] && lvl_ovf != TIC_LVL_OFF;
         error_irq          <= interrupt_flags_nxt[TIC_I_ERR] && lvl_err != TIC_LVL_OFF;
         channel_irq        <= cc_irq_nxt;
      end
   end

endmodule : tic_irq_ctrl

// ---- verif/tic_irq_ctrl_asserts.sv ----
// Purpose: port-level checks for the timer interrupt, command and flag block
// Assumes: one clock, rst asynchronous and active high
// Notes:   bound to the design from the bench top file
`timescale 1ns/1ps
module tic_irq_ctrl_asserts
   import tic_pkg::*;
(
   input wire logic       clk, rst, bus_wr, bus_rd, timer_off, top_event, bottom_event,
   input wire logic       dma_cnt_per_write, cmd_update, cmd_restart, cmd_hard_reset,
   input wire logic       overflow_dma_req, overflow_irq, error_irq,
   input wire logic [5:0] bus_addr,
   input wire logic [7:0] bus_wdata, bus_rdata, channel_irq_level,
   input wire logic [2:0] waveform_mode,
   input wire logic [1:0] overflow_irq_level, error_irq_level
);
   // ****************************************
   // write decode sequences
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_wr(logic [5:0] a);
      bus_wr && bus_addr == a;
   endsequence
   sequence s_cmd(logic [1:0] c);
      s_wr(TIC_OFF_F_SET) ##0 bus_wdata[3:2] == c;
   endsequence
   a_update_cmd: assert property (s_cmd(TIC_CMD_UPDATE) |=> cmd_update)
      else $error("update command gave no pulse");
   a_restart_cmd: assert property (s_cmd(TIC_CMD_RESTART) |=> cmd_restart && !cmd_update)
      else $error("restart command decoded wrongly");
   a_reset_when_off: assert property (s_cmd(TIC_CMD_RESET) |=> cmd_hard_reset == $past(timer_off))
      else $error("hard reset not gated by timer off");
   a_level_a_copy: assert property (s_wr(TIC_OFF_IRQ_A) |=> {error_irq_level, overflow_irq_level} == $past(bus_wdata[3:0]))
      else $error("level fields of register a not taken");
   a_level_b_copy: assert property (s_wr(TIC_OFF_IRQ_B) |=> channel_irq_level == $past(bus_wdata))
      else $error("channel level fields not taken");
   a_cmd_read_zero: assert property (bus_rd && bus_addr[5:1] == 5'h04 |=> bus_rdata[7:5] == 3'h0 && bus_rdata[3:2] == 2'h0)
      else $error("command or reserved bits read nonzero");
   a_ovf_on_top: assert property (top_event && waveform_mode == TIC_WG_NORMAL |=> overflow_dma_req)
      else $error("overflow flag missed top");
   a_ovf_dma_clear: assert property (dma_cnt_per_write && !top_event && !bottom_event |=> !overflow_dma_req)
      else $error("counter write kept overflow request");
   a_ovf_irq_gate: assert property (overflow_irq == (overflow_dma_req && overflow_irq_level != TIC_LVL_OFF))
      else $error("overflow request not flag and level");
   a_err_irq_gate: assert property (error_irq |-> error_irq_level != TIC_LVL_OFF)
      else $error("error request with level off");
endmodule : tic_irq_ctrl_asserts

// ---- verif/tic_bus_model.sv ----
// Purpose: processor side of the internal register bus
// Assumes: strobes held for one taken edge, read data one cycle later
// Notes:   released address and data are inverted so stale values never match
`timescale 1ns/1ps
module tic_bus_model
   import tic_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] bus_rdata,
   output logic      [5:0] bus_addr,
   output logic      [7:0] bus_wdata,
   output logic            bus_wr,
   output logic            bus_rd,
   output logic            bus_dma
);
   initial begin
      {bus_addr, bus_wdata, bus_wr, bus_rd, bus_dma} = '0;
   end
   // one access per call; a flag is cleared only by the ones that the caller writes
   task automatic access(input logic [5:0] a, input logic [7:0] dv, input logic w, output logic [7:0] q);
      @(posedge clk);
      #1;
      {bus_addr, bus_wdata, bus_wr, bus_rd} = {a, dv, w, !w};
      @(posedge clk);
      #1;
      {bus_addr, bus_wdata, bus_wr, bus_rd} = {~a, ~dv, 2'b00};
      q = bus_rdata;
   endtask : access
endmodule : tic_bus_model

// ---- verif/tic_irq_ctrl_test.sv ----
// Purpose: self-checking bench for the timer interrupt, command and flag block
// Assumes: 25 MHz clock, datapath pulses driven one cycle at a time
// Notes:   table rows cover register access, hand tests cover events
`timescale 1ns/1ps
module tic_irq_ctrl_test
   import tic_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, timer_off = 1'b0, has_waveform_extension = 1'b0;
   logic [2:0] event_action = 3'h0, waveform_mode = 3'h0;
   logic update_cond, top_event, bottom_event, fault_detect, bad_index, index_seen, leave_zero;
   logic hw_dir_set, hw_dir_clr, per_buf_written, dma_cnt_per_write, vec_ovf_ack, vec_err_ack;
   logic [3:0] cc_match, cc_capture, cc_buf_overflow, cc_buf_written, cc_read, dma_cc_access, vec_cc_ack;
   logic [3:0] copy_cc_buffer, channel_dma_req, channel_irq;
   logic [5:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata, channel_irq_level, d;
   logic [1:0] overflow_irq_level, error_irq_level;
   logic bus_wr, bus_rd, bus_dma, cmd_update, cmd_restart, cmd_hard_reset, transfer_buffers;
   logic count_down, quad_index_flag, overflow_dma_req, overflow_irq, error_irq;
   int n_errors = 0, n_compared = 0, cyc = 0;
   logic [7:0] rows [10][4] = '{'{8'h06, 8'hFF, 8'h06, 8'h0F}, '{8'h07, 8'hA5, 8'h07, 8'hA5},
      '{8'h09, 8'h13, 8'h08, 8'h13}, '{8'h08, 8'h12, 8'h09, 8'h01}, '{8'h09, 8'h0C, 8'h09, 8'h01},
      '{8'h08, 8'h01, 8'h08, 8'h00}, '{8'h0B, 8'h1F, 8'h0A, 8'h1F}, '{8'h0A, 8'h1F, 8'h0B, 8'h00},
      '{8'h05, 8'hFF, 8'h05, 8'h00}, '{8'h0C, 8'hFF, 8'h0C, 8'h00}};
   tic_irq_ctrl dut (.*);
   tic_bus_model m (.*);
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         finish_test;
      end
   end
   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      m.access(a, v, 1'b1, d);
   endtask : wr
   task automatic rdchk(input string nm, input logic [5:0] a, input logic [7:0] e);
      m.access(a, 8'h00, 1'b0, d);
      chk(nm, d, e);
   endtask : rdchk
   // pulses drop on the taking edge itself, so a new pulse one step later never collides
   task automatic tick;
      @(posedge clk);
      {update_cond, top_event, bottom_event, fault_detect, bad_index, index_seen, leave_zero, hw_dir_set,
       hw_dir_clr, per_buf_written, dma_cnt_per_write, vec_ovf_ack, vec_err_ack, cc_match, cc_capture,
       cc_buf_overflow, cc_buf_written, cc_read, dma_cc_access, vec_cc_ack} <= '0;
      #1;
   endtask : tick
   task automatic finish_test;
      if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      tick;
      repeat (9) @(posedge clk);
      #1;
      rst = 1'b0;
      for (int a = 6; a < 13; a++) rdchk("reset", a[5:0], TIC_RST_BYTE);
      for (int i = 0; i < 10; i++) begin
         wr(rows[i][0][5:0], rows[i][1]);
         rdchk("row", rows[i][2][5:0], rows[i][3]);
      end
      wr(TIC_OFF_F_SET, 8'h04);
      chk("update", 8'({cmd_update, transfer_buffers, cmd_restart}), 8'h06);
      wr(TIC_OFF_F_SET, 8'h08);
      chk("restart", 8'({cmd_update, cmd_restart}), 8'h01);
      wr(TIC_OFF_F_SET, 8'h0C);
      chk("reset running", 8'(cmd_hard_reset), 8'h00);
      timer_off = 1'b1;
      wr(TIC_OFF_F_SET, 8'h0C);
      chk("reset off", 8'(cmd_hard_reset), 8'h01);
      wr(TIC_OFF_F_SET, 8'h02);
      update_cond = 1'b1;
      tick;
      chk("locked", 8'(transfer_buffers), 8'h00);
      event_action = TIC_EV_CAPT;
      update_cond = 1'b1;
      tick;
      chk("lock capture", 8'(transfer_buffers), 8'h01);
      event_action = 3'h0;
      wr(TIC_OFF_F_CLR, 8'h02);
      cc_buf_written = 4'h5;
      per_buf_written = 1'b1;
      tick;
      rdchk("valid", TIC_OFF_G_SET, 8'h0B);
      update_cond = 1'b1;
      tick;
      chk("copy", 8'({transfer_buffers, |copy_cc_buffer}), 8'h03);
      rdchk("valid clr", TIC_OFF_G_CLR, 8'h00);
      cc_match = 4'hB;
      tick;
      chk("match", {channel_dma_req, channel_irq}, 8'hBB);
      vec_cc_ack = 4'h1;
      tick;
      wr(TIC_OFF_FLAGS, 8'h20);
      rdchk("w1c", TIC_OFF_FLAGS, 8'h80);
      dma_cc_access = 4'h8;
      tick;
      chk("dma clr", 8'(channel_dma_req), 8'h00);
      wr(TIC_OFF_IRQ_B, 8'h00);
      cc_match = 4'h1;
      tick;
      chk("level off", {channel_dma_req, channel_irq}, 8'h10);
      wr(TIC_OFF_FLAGS, 8'h10);
      event_action = TIC_EV_PW;
      cc_capture = 4'h4;
      cc_buf_overflow = 4'h2;
      tick;
      rdchk("capture", TIC_OFF_FLAGS, 8'h42);
      rdchk("capt valid", TIC_OFF_G_SET, 8'h08);
      vec_cc_ack = 4'h4;
      vec_err_ack = 1'b1;
      tick;
      rdchk("vector", TIC_OFF_FLAGS, 8'h40);
      cc_read = 4'h4;
      tick;
      chk("read clr", 8'(channel_dma_req), 8'h00);
      rdchk("capt drop", TIC_OFF_G_CLR, 8'h00);
      event_action = 3'h0;
      waveform_mode = 3'h3;
      fault_detect = 1'b1;
      tick;
      chk("no ext", 8'(error_irq), 8'h00);
      has_waveform_extension = 1'b1;
      fault_detect = 1'b1;
      tick;
      chk("fault", 8'(error_irq), 8'h01);
      wr(TIC_OFF_FLAGS, 8'h02);
      chk("err w1c", 8'(error_irq), 8'h00);
      waveform_mode = TIC_WG_NORMAL;
      bad_index = 1'b1;
      tick;
      chk("index err", 8'(error_irq), 8'h01);
      top_event = 1'b1;
      tick;
      chk("ovf", 8'({overflow_dma_req, overflow_irq}), 8'h03);
      vec_ovf_ack = 1'b1;
      tick;
      chk("ovf vec", 8'(overflow_dma_req), 8'h00);
      top_event = 1'b1;
      tick;
      dma_cnt_per_write = 1'b1;
      tick;
      chk("ovf dma", 8'(overflow_dma_req), 8'h00);
      index_seen = 1'b1;
      hw_dir_set = 1'b1;
      tick;
      chk("idx dir", 8'({quad_index_flag, count_down}), 8'h03);
      leave_zero = 1'b1;
      hw_dir_clr = 1'b1;
      tick;
      chk("idx dir clr", 8'({quad_index_flag, count_down}), 8'h00);
      finish_test;
   end
endmodule : tic_irq_ctrl_test
bind tic_irq_ctrl tic_irq_ctrl_asserts u_chk (.*);
